// File: common/pipe_bank_pkg.sv
/*
  shared constants for the dual pipeline register bank: widths, depths,
  load operation codes, select layout, fifo sizing and reset values.
  assumes nothing of its surroundings.
*/
package pipe_bank_pkg;

  localparam int unsigned DATA_W      = 8;
  localparam int unsigned SIDE_DEPTH  = 8;
  localparam int unsigned TOTAL_DEPTH = 16;
  localparam int unsigned SEL_W       = 4;
  localparam int unsigned SEL_SIDE_BIT = 3;

  localparam int unsigned FIFO_DEPTH  = 16;
  localparam int unsigned FIFO_AW     = 4;

  typedef enum logic [1:0] {
    OP_PUSH_BOTH   = 2'h0,
    OP_LOAD_SECOND = 2'h1,
    OP_LOAD_FIRST  = 2'h2,
    OP_FREEZE_ALL  = 2'h3
  } load_op_t;

  localparam logic [DATA_W-1:0]  STAGE_RST = 8'h00;
  localparam logic [FIFO_AW-1:0] PTR_RST   = 4'h0;
  localparam logic [FIFO_AW:0]   CNT_RST   = 5'h00;

endpackage : pipe_bank_pkg

// File: design/word_fifo.sv
/*
  synchronous fifo with valid/ready on both sides, flip-flop storage.
  assumes one clock, a synchronous active-high reset and a clock enable.
*/
`timescale 1ns/1ns
`default_nettype none
module word_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16,
  parameter int unsigned AW    = 4
) (
  input  wire logic             ref_clk,
  input  wire logic             srst,
  input  wire logic             clk_en,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wr;
    logic [AW-1:0]               rd;
    logic [AW:0]                 cnt;
  } fifo_state_t;

  fifo_state_t s_q;
  fifo_state_t s_d;
  logic        push;
  logic        pop;

  // full is a count equal to the depth, which needs the extra count bit
  assign in_ready  = (s_q.cnt != (AW+1)'(DEPTH));
  assign out_valid = (s_q.cnt != '0);
  assign out_data  = s_q.mem[s_q.rd];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_comb begin
    s_d = s_q;
    if (push) begin
      s_d.mem[s_q.wr] = in_data;
      s_d.wr          = s_q.wr + AW'(1);
    end
    if (pop) begin
      s_d.rd = s_q.rd + AW'(1);
    end
    s_d.cnt = s_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      s_q <= '0;
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  a_fifo_no_overrun: assert property (@(posedge ref_clk) disable iff (srst)
    s_q.cnt <= (AW+1)'(DEPTH)) else $error("fifo count above depth");
endmodule : word_fifo
`default_nettype wire

// File: design/pipe_bank.sv
/*
  dual 8-stage pipeline register bank: two sides chained or independent,
  with a three-state read port chosen by a select. input words pass a
  16-word fifo; a load operation only fires when a word is available.
  assumes host logic on ref_clk drives data, op code, select and enable.
*/
// Notes on behaviour
// RULE1 - sixteen 8-bit stages in sides A and B, two 8-deep or one 16-deep pipe
// RULE2 - op 00 loads input into A0 and shifts A on each enabled edge with a fifo word available
// RULE3 - op 00 also moves A7 into B0, shifts B, drops B7
// RULE4 - op 01 loads input into B0, shifts B only, A holds
// RULE5 - op 10 loads input into A0, shifts A only, B holds
// RULE6 - op 11 changes no stage at all
// RULE7 - select 0-7 reads A0-A7, 8-15 reads B0-B7
// RULE8 - select read is independent of the op code, same cycle
// RULE9 - input and output travel on separate 8-bit buses
// RULE10 - low enable drives output; otherwise released, stages unaffected
`timescale 1ns/1ns
`default_nettype none
module pipe_bank
  import pipe_bank_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              srst,
  input  wire logic              clk_en,
  input  wire logic [1:0]        load_op_code,
  input  wire logic              in_valid,
  output logic                   in_ready,
  input  wire logic [DATA_W-1:0] input_bus,
  input  wire logic [SEL_W-1:0]  output_select,
  input  wire logic              output_en_n,
  output logic      [DATA_W-1:0] output_bus,
  output logic                   output_bus_oe
);
  typedef struct packed {
    logic [SIDE_DEPTH-1:0][DATA_W-1:0] side_a;                 // [RULE1]
    logic [SIDE_DEPTH-1:0][DATA_W-1:0] side_b;
    logic [DATA_W-1:0]                 rd_data;
    logic                              rd_oe;
  } bank_state_t;

  bank_state_t       s_q;
  bank_state_t       s_d;
  logic              word_valid;
  logic              word_take;
  logic [DATA_W-1:0] word;
  load_op_t          op;
  logic              op_moves;

  assign op       = load_op_t'(load_op_code);
  assign op_moves = (op != OP_FREEZE_ALL);
  // a word is consumed only by an op that loads it
  assign word_take = word_valid & op_moves;

  word_fifo #(
    .WIDTH(DATA_W),
    .DEPTH(FIFO_DEPTH),
    .AW   (FIFO_AW)
  ) u_in_fifo (
    .ref_clk  (ref_clk),
    .srst     (srst),
    .clk_en   (clk_en),
    .in_valid (in_valid),
    .in_ready (in_ready),
    .in_data  (input_bus),   // [RULE9]
    .out_valid(word_valid),
    .out_ready(word_take),
    .out_data (word)
  );

  always_comb begin
    s_d = s_q;
    if (word_valid) begin
      case (op)
        OP_PUSH_BOTH: begin
          s_d.side_a = {s_q.side_a[SIDE_DEPTH-2:0], word};                       // [RULE2]
          s_d.side_b = {s_q.side_b[SIDE_DEPTH-2:0], s_q.side_a[SIDE_DEPTH-1]};   // [RULE3]
        end
        OP_LOAD_SECOND: begin
          s_d.side_b = {s_q.side_b[SIDE_DEPTH-2:0], word};                       // [RULE4]
        end
        OP_LOAD_FIRST: begin
          s_d.side_a = {s_q.side_a[SIDE_DEPTH-2:0], word};                       // [RULE5]
        end
        OP_FREEZE_ALL: begin
          s_d.side_a = s_q.side_a;                                               // [RULE6]
        end
        default: begin
          s_d.side_a = s_q.side_a;
        end
      endcase
    end
    // read port registered from the next state so it follows this edge's load
    if (output_select[SEL_SIDE_BIT]) begin
      s_d.rd_data = s_d.side_b[output_select[SEL_SIDE_BIT-1:0]];                 // [RULE7] [RULE8]
    end else begin
      s_d.rd_data = s_d.side_a[output_select[SEL_SIDE_BIT-1:0]];                 // [RULE7]
    end
    s_d.rd_oe = ~output_en_n;                                                    // [RULE10]
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      s_q <= '0;
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  assign output_bus    = s_q.rd_data;
  assign output_bus_oe = s_q.rd_oe;

  a_push_both_shift: assert property (@(posedge ref_clk) disable iff (srst)
    clk_en && word_valid && op == OP_PUSH_BOTH |=>
      s_q.side_a[0] == $past(word) && s_q.side_b[0] == $past(s_q.side_a[7])
      && s_q.side_a[7] == $past(s_q.side_a[6]))
    else $error("push both did not shift");  // [RULE2] [RULE3]
  a_last_b_dropped: assert property (@(posedge ref_clk) disable iff (srst)
    clk_en && word_valid && op == OP_PUSH_BOTH |=>
      s_q.side_b[7] == $past(s_q.side_b[6]))
    else $error("b side end not shifted");  // [RULE3]
  a_load_b_only: assert property (@(posedge ref_clk) disable iff (srst)
    clk_en && word_valid && op == OP_LOAD_SECOND |=>
      s_q.side_b[0] == $past(word) && $stable(s_q.side_a))
    else $error("load b wrong");  // [RULE4]
  a_load_a_only: assert property (@(posedge ref_clk) disable iff (srst)
    clk_en && word_valid && op == OP_LOAD_FIRST |=>
      s_q.side_a[0] == $past(word) && $stable(s_q.side_b))
    else $error("load a wrong");  // [RULE5]
  a_freeze_holds: assert property (@(posedge ref_clk) disable iff (srst)
    op == OP_FREEZE_ALL |=> $stable(s_q.side_a) && $stable(s_q.side_b))
    else $error("freeze changed a stage");  // [RULE6]
  a_select_reads: assert property (@(posedge ref_clk) disable iff (srst)
    clk_en |=> output_bus == ($past(output_select[3]) ? s_q.side_b[$past(output_select[2:0])]
      : s_q.side_a[$past(output_select[2:0])]))
    else $error("select reads wrong stage");  // [RULE7]
  a_read_while_load: assert property (@(posedge ref_clk) disable iff (srst)
    clk_en && word_valid && op == OP_LOAD_FIRST && output_select == 4'h0 |=>
      output_bus == $past(word))
    else $error("same cycle read missed");  // [RULE8]
  a_enable_drive: assert property (@(posedge ref_clk) disable iff (srst)
    clk_en |=> output_bus_oe == !$past(output_en_n))
    else $error("output enable wrong");  // [RULE10]
endmodule : pipe_bank
`default_nettype wire

// File: testbench/host_model.sv
/* host side: offers words 1, 2, 3.. on the input bus until quota is met.
   assumes the bench clock and a bank that takes words on valid and ready. */
`timescale 1ns/1ns
`default_nettype none
module host_model (
  input  wire logic       ref_clk,
  input  wire logic       srst,
  input  wire logic       in_ready,
  input  wire logic [7:0] quota,
  output logic            in_valid,
  output logic      [7:0] input_bus,
  output logic      [7:0] sent
);
  logic       taken;
  logic [7:0] n;
  initial begin
    taken = 1'b0;
    in_valid = 1'b0;
    input_bus = 8'h5a;
    sent = 8'h00;
  end
  always @(posedge ref_clk) taken <= in_valid & in_ready;
  // a word stays put until taken; an idle bus toggles so stale data never passes
  always @(negedge ref_clk) begin
    n = srst ? 8'h00 : sent + {7'h00, taken};
    sent      <= n;
    in_valid  <= !srst && n < quota;
    input_bus <= (!srst && n < quota) ? n + 8'h01 : ~input_bus;
  end
endmodule : host_model
`default_nettype wire

// File: testbench/testbench.sv
/* self-checking bench for the pipeline register bank.
   assumes the package, the bank with its fifo and host_model are compiled first. */
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import pipe_bank_pkg::*;
  logic              ref_clk = 1'b0;
  logic              srst = 1'b1;
  logic              clk_en = 1'b1;
  logic              output_en_n = 1'b0;
  logic [1:0]        op = 2'h3;
  logic [SEL_W-1:0]  sel = 4'h0;
  logic [7:0]        quota = 8'h00;
  logic [7:0]        nw = 8'h00;
  logic [DATA_W-1:0] m [TOTAL_DEPTH];
  int                n_fail = 0;
  int                tests_run = 0;
  wire logic         in_valid, in_ready, oe;
  wire logic [7:0]   din, dout, sent;
  wire logic [7:0]   ybus = oe ? dout : 8'hzz;
  always #2 ref_clk = ~ref_clk;
  host_model host (.ref_clk(ref_clk), .srst(srst), .in_ready(in_ready), .quota(quota),
                   .in_valid(in_valid), .input_bus(din), .sent(sent));
  pipe_bank dut (.ref_clk(ref_clk), .srst(srst), .clk_en(clk_en), .load_op_code(op),
                 .in_valid(in_valid), .in_ready(in_ready), .input_bus(din),
                 .output_select(sel), .output_en_n(output_en_n), .output_bus(dout),
                 .output_bus_oe(oe));
  task automatic chk(input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask : chk
  function automatic logic [7:0] seen(input int j);
    return output_en_n ? 8'hzz : m[j];
  endfunction : seen
  task automatic model_load(input logic [1:0] o, input logic [7:0] w);
    if (o != OP_LOAD_FIRST) begin
      for (int j = 15; j > 8; j--) m[j] = m[j-1];
      m[8] = (o == OP_PUSH_BOTH) ? m[7] : w;
    end
    if (o != OP_LOAD_SECOND) begin
      for (int j = 7; j > 0; j--) m[j] = m[j-1];
      m[0] = w;
    end
  endtask : model_load
  task automatic rd(input int j);
    @(negedge ref_clk) sel = j[3:0];
    @(negedge ref_clk) chk(seen(j), ybus);
  endtask : rd
  task automatic readall();
    for (int j = 0; j < TOTAL_DEPTH; j++) rd(j);
  endtask : readall
  // watch is a stage of the side that the op leaves alone; push both moves both sides, so watch goes unchecked
  task automatic phase(input logic [1:0] o, input logic [7:0] k, input int watch);
    @(negedge ref_clk) op = o;
    sel = watch[3:0];
    quota = quota + k;
    for (int i = 0; i < 60 && sent !== quota; i++) begin
      @(negedge ref_clk);
      if (o != OP_PUSH_BOTH) chk(seen(watch), ybus);
    end
    // the fifo may still hold up to a full depth of words after the last is sent
    repeat (FIFO_DEPTH + 4) @(negedge ref_clk);
    op = OP_FREEZE_ALL;
    for (; nw != sent; nw++) model_load(o, nw + 8'h01);
  endtask : phase
  task automatic freeze_fill();
    @(negedge ref_clk) op = OP_FREEZE_ALL;
    quota = quota + 8'd20;
    repeat (30) @(negedge ref_clk);
    chk(quota - 8'd4, sent);
    chk(8'h00, {7'h00, in_ready});
    readall();
    phase(OP_PUSH_BOTH, 8'h00, 0);
    readall();
  endtask : freeze_fill
  // clock enable low must hold the registered read port as well
  task automatic stall();
    @(negedge ref_clk) sel = 4'h8;
    @(negedge ref_clk) clk_en = 1'b0;
    sel = 4'h1;
    repeat (3) @(negedge ref_clk);
    chk(seen(8), ybus);
    clk_en = 1'b1;
    rd(1);
  endtask : stall
  task automatic results();
    if (n_fail == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : results
  initial begin
    foreach (m[j]) m[j] = STAGE_RST;
    repeat (12) @(negedge ref_clk);
    srst = 1'b0;
    readall();
    phase(OP_LOAD_FIRST, 8'd3, 8);
    phase(OP_LOAD_SECOND, 8'd3, 0);
    readall();
    stall();
    freeze_fill();
    phase(OP_PUSH_BOTH, 8'd5, 0);
    readall();
    output_en_n = 1'b1;
    phase(OP_LOAD_FIRST, 8'd2, 8);
    readall();
    output_en_n = 1'b0;
    readall();
    results();
  end
  initial begin
    #(4 * 4000);
    n_fail++;
    results();
  end
endmodule : testbench
`default_nettype wire
